// >>> logic/dtm_pkg.sv
// constants shared by the dual reload timer block
// Behaviour
// R1: two independent 16-bit timers, each reload timer or free-running counter
// R2: both timers count on the system clock only
// R3: control byte bits 7-4 timer b flag/mode/run/irq, bits 3-0 same for timer a
// R4: hardware sets overflow flag on overflow; only software clears it
// R5: mode bit 1 selects auto-reload, 0 selects free-running
// R6: timer counts only while run bit set; clearing stops it
// R7: irq enable 1 lets overflow raise interrupt; 0 suppresses it
// R8: timer a irq enable gates timer a interrupt independently of timer b
// R9: in reload mode, count byte writes go to the reload register
// R10: in free-run mode, count byte writes load the live counter at once
// R11: count byte reads always return the live counter
// R12: no snapshot latch; each byte read shows counter at that moment
// R13: software should read high byte first, then low byte
// R14: timer a low byte at 0xae, high byte at 0xaf
// R15: timer b low byte at 0xac, high byte at 0xad
// R16: all count bytes reset to zero and are read/write
// R17: overflow reloads from reload register in reload mode, else wraps to zero
// R18: stopped timer holds count and never sets its overflow flag
package dtm_pkg;
  localparam int DTM_ADDR_W = 8;
  localparam logic [7:0] DTM_B_LOW_OFS = 8'hac;
  localparam logic [7:0] DTM_B_HIGH_OFS = 8'had;
  localparam logic [7:0] DTM_A_LOW_OFS = 8'hae;
  localparam logic [7:0] DTM_A_HIGH_OFS = 8'haf;
  localparam logic [7:0] DTM_CTRL_OFS = 8'hab;
  localparam logic [7:0] DTM_CTRL_RESET = 8'h00;
  localparam logic [15:0] DTM_COUNT_RESET = 16'h0000;
  localparam int DTM_FLAG_BIT = 3;
  localparam int DTM_MODE_BIT = 2;
  localparam int DTM_RUN_BIT = 1;
  localparam int DTM_IEN_BIT = 0;
  localparam int DTM_B_NIBBLE = 4;
  localparam int DTM_A_NIBBLE = 0;
endpackage

// >>> logic/dtm_timer.sv
// one 16-bit reload timer or free-running counter
module dtm_timer
  import dtm_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic reload_mode,
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic [7:0] wr_data,
  output logic [WIDTH-1:0] count,
  output logic overflow
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] reload_reg;
  logic [WIDTH-1:0] count_next;
  logic ovf;

  assign ovf = run && (count_reg == {WIDTH{1'b1}}); // [R18]

  always_comb begin
    count_next = count_reg;
    if (run) begin // [R6] [R18]
      if (ovf) begin
        count_next = reload_mode ? reload_reg : '0; // [R17] [R5]
      end else begin
        count_next = count_reg + 1'b1; // [R2]
      end
    end
    if (!reload_mode && wr_low) begin
      count_next[7:0] = wr_data; // [R10]
    end
    if (!reload_mode && wr_high) begin
      count_next[15:8] = wr_data; // [R10]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_reg <= DTM_COUNT_RESET; // [R16]
    end else begin
      count_reg <= count_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reload_reg <= DTM_COUNT_RESET;
    end else begin
      if (reload_mode && wr_low) begin
        reload_reg[7:0] <= wr_data; // [R9]
      end
      if (reload_mode && wr_high) begin
        reload_reg[15:8] <= wr_data; // [R9]
      end
    end
  end

  assign count = count_reg;
  assign overflow = ovf;
endmodule

// >>> logic/dtm_wb_slave.sv
// classic wishbone single-cycle slave handshake
module dtm_wb_slave (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cyc,
  input wire logic stb,
  input wire logic we,
  input wire logic sel,
  output logic ack,
  output logic wr_pulse,
  output logic rd_pulse
);
  logic ack_reg;
  logic req;

  assign req = cyc && stb && !ack_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  assign ack = ack_reg;
  assign wr_pulse = req && we && sel;
  assign rd_pulse = req && !we;
endmodule

// >>> logic/dtm_top.sv
// dual 16-bit system timers with wishbone register access
module dtm_top
  import dtm_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [dtm_pkg::DTM_ADDR_W-1:0] WB_ADR_I,
  input wire logic [7:0] WB_DAT_I,
  input wire logic WB_SEL_I,
  output logic [7:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic TIMER_A_IRQ,
  output logic TIMER_B_IRQ
);
  import dtm_pkg::*;

  // ************************************************************
  // bus front end
  // ************************************************************
  logic wr_pulse;
  logic rd_pulse;
  logic [7:0] ctrl_reg;
  logic [7:0] dat_o_reg;
  logic irq_a_reg;
  logic irq_b_reg;
  logic [15:0] count_a;
  logic [15:0] count_b;
  logic ovf_a;
  logic ovf_b;

  dtm_wb_slave u_wb (
    .clk(MCLK),
    .rst_n(RESET_N),
    .cyc(WB_CYC_I),
    .stb(WB_STB_I),
    .we(WB_WE_I),
    .sel(WB_SEL_I),
    .ack(WB_ACK_O),
    .wr_pulse(wr_pulse),
    .rd_pulse(rd_pulse)
  );

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr == ofs);
  endfunction

  // ************************************************************
  // timers
  // ************************************************************
  localparam int A = DTM_A_NIBBLE;
  localparam int B = DTM_B_NIBBLE;

  dtm_timer #(.WIDTH(16)) u_timer_a ( // [R1]
    .clk(MCLK),
    .rst_n(RESET_N),
    .run(ctrl_reg[A+DTM_RUN_BIT]),
    .reload_mode(ctrl_reg[A+DTM_MODE_BIT]),
    .wr_low(wr_pulse && hit(WB_ADR_I, DTM_A_LOW_OFS)), // [R14]
    .wr_high(wr_pulse && hit(WB_ADR_I, DTM_A_HIGH_OFS)), // [R14]
    .wr_data(WB_DAT_I),
    .count(count_a),
    .overflow(ovf_a)
  );

  dtm_timer #(.WIDTH(16)) u_timer_b ( // [R1]
    .clk(MCLK),
    .rst_n(RESET_N),
    .run(ctrl_reg[B+DTM_RUN_BIT]),
    .reload_mode(ctrl_reg[B+DTM_MODE_BIT]),
    .wr_low(wr_pulse && hit(WB_ADR_I, DTM_B_LOW_OFS)), // [R15]
    .wr_high(wr_pulse && hit(WB_ADR_I, DTM_B_HIGH_OFS)), // [R15]
    .wr_data(WB_DAT_I),
    .count(count_b),
    .overflow(ovf_b)
  );

  // ************************************************************
  // control byte
  // ************************************************************
  logic ctrl_wr;
  assign ctrl_wr = wr_pulse && hit(WB_ADR_I, DTM_CTRL_OFS);

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      ctrl_reg <= DTM_CTRL_RESET;
    end else begin
      if (ctrl_wr) begin
        ctrl_reg <= WB_DAT_I; // [R3]
      end
      // set beats software clear
      if (ovf_a) begin
        ctrl_reg[A+DTM_FLAG_BIT] <= 1'b1; // [R4]
      end
      if (ovf_b) begin
        ctrl_reg[B+DTM_FLAG_BIT] <= 1'b1; // [R4]
      end
    end
  end

  // ************************************************************
  // interrupt requests
  // ************************************************************
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      irq_a_reg <= 1'b0;
      irq_b_reg <= 1'b0;
    end else begin
      irq_a_reg <= ctrl_reg[A+DTM_FLAG_BIT] && ctrl_reg[A+DTM_IEN_BIT]; // [R7] [R8]
      irq_b_reg <= ctrl_reg[B+DTM_FLAG_BIT] && ctrl_reg[B+DTM_IEN_BIT]; // [R7]
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      dat_o_reg <= 8'h00;
    end else if (rd_pulse) begin
      unique case (WB_ADR_I)
        DTM_A_LOW_OFS: dat_o_reg <= count_a[7:0]; // [R11] [R12]
        DTM_A_HIGH_OFS: dat_o_reg <= count_a[15:8]; // [R11] [R12]
        DTM_B_LOW_OFS: dat_o_reg <= count_b[7:0]; // [R11]
        DTM_B_HIGH_OFS: dat_o_reg <= count_b[15:8]; // [R11]
        DTM_CTRL_OFS: dat_o_reg <= ctrl_reg;
        default: dat_o_reg <= 8'h00;
      endcase
    end
  end

  assign WB_DAT_O = dat_o_reg;
  assign TIMER_A_IRQ = irq_a_reg;
  assign TIMER_B_IRQ = irq_b_reg;
endmodule

// >>> test/dtm_top_sva.sv
// concurrent checks on the dual reload timer block ports
module dtm_top_chk
  import dtm_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [DTM_ADDR_W-1:0] WB_ADR_I,
  input wire logic [7:0] WB_DAT_I,
  input wire logic WB_SEL_I,
  input wire logic WB_ACK_O,
  input wire logic TIMER_A_IRQ,
  input wire logic TIMER_B_IRQ
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  wire req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  wire wr_ctl = req && WB_WE_I && WB_SEL_I && WB_ADR_I == DTM_CTRL_OFS;
  wire [7:0] d = WB_DAT_I;
  a_ack_follows: assert property (req |=> WB_ACK_O) else $error("no ack");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("long ack");
  a_irq_a_off: assert property (wr_ctl && !d[0] |=> ##1 !TIMER_A_IRQ) else $error("a irq on");
  a_irq_b_off: assert property (wr_ctl && !d[4] |=> ##1 !TIMER_B_IRQ) else $error("b irq on");
  a_irq_a_on: assert property (wr_ctl && d[3] && d[0] |=> ##1 TIMER_A_IRQ) else $error("a irq off");
  a_irq_b_on: assert property (wr_ctl && d[7] && d[4] |=> ##1 TIMER_B_IRQ) else $error("b irq off");
  a_flag_a_sticky: assert property ($fell(TIMER_A_IRQ) |-> $past(wr_ctl, 2)) else $error("a irq fell");
  a_flag_b_sticky: assert property ($fell(TIMER_B_IRQ) |-> $past(wr_ctl, 2)) else $error("b irq fell");
  cover property (wr_ctl && d[3]);
  cover property ($rose(TIMER_A_IRQ));
  cover property ($rose(TIMER_B_IRQ));
endmodule
bind dtm_top dtm_top_chk i_dtm_top_chk (.MCLK(MCLK), .RESET_N(RESET_N), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_SEL_I(WB_SEL_I),
  .WB_ACK_O(WB_ACK_O), .TIMER_A_IRQ(TIMER_A_IRQ), .TIMER_B_IRQ(TIMER_B_IRQ));

// >>> test/dtm_top_test.sv
// self-checking bench for the dual reload timer block
`define CHK(a, e, m) begin cmp_count++; if ((a) !== (e)) begin errors++; \
  $display("wrong value %0t %s", $time, m); end end
module dtm_top_test
  import dtm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk;
  logic reset_n = 1'h0;
  logic cyc = 1'h0;
  logic we = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [7:0] dat = 8'h00;
  logic [7:0] q;
  wire [7:0] rd;
  wire ack;
  wire [1:0] irq;
  int errors = 0;
  int cmp_count = 0;
  dtm_top i_dtm_top (.MCLK(mclk), .RESET_N(reset_n), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_SEL_I(1'h1), .WB_DAT_O(rd), .WB_ACK_O(ack),
    .TIMER_A_IRQ(irq[0]), .TIMER_B_IRQ(irq[1]));
  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end
  // request held until ack is sampled high at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'h1 && n < 20);
    if (ack !== 1'h1) begin
      errors++;
      $display("wrong value %0t %s", $time, "no ack");
    end
    q = rd;
    cyc <= 1'h0;
  endtask
  task automatic rdchk(input logic [7:0] a, e, input string m);
    wb(1'h0, a, 8'h00);
    `CHK(q, e, m)
  endtask
  task automatic summarize();
    if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_reset();
    for (int a = 8'hab; a < 8'hb0; a++) rdchk(a[7:0], 8'h00, "reset");
    rdchk(8'h00, 8'h00, "unmapped");
  endtask
  // m picks the mode for the overflow run
  task automatic t_timer(input int b, input logic m);
    logic [7:0] lo, md, v;
    int s;
    lo = b ? DTM_B_LOW_OFS : DTM_A_LOW_OFS;
    s = b ? DTM_B_NIBBLE : DTM_A_NIBBLE;
    md = {5'h00, m, 2'h0};
    wb(1'h1, DTM_CTRL_OFS, 8'h04 << s);
    wb(1'h1, lo, 8'h34);
    wb(1'h1, lo + 8'h01, 8'h12);
    rdchk(lo + 8'h01, 8'h00, "reload hit count");
    wb(1'h1, DTM_CTRL_OFS, 8'h00);
    wb(1'h1, lo, 8'hfe);
    wb(1'h1, lo + 8'h01, 8'hff);
    rdchk(lo + 8'h01, 8'hff, "load high");
    rdchk(lo, 8'hfe, "load low");
    wb(1'h1, DTM_CTRL_OFS, (md | 8'h02) << s);
    repeat (30) @(posedge mclk);
    rdchk(DTM_CTRL_OFS, (md | 8'h0a) << s, "flag");
    wb(1'h1, DTM_CTRL_OFS, (md | 8'h08) << s);
    rdchk(lo + 8'h01, m ? 8'h12 : 8'h00, "wrap");
    wb(1'h0, lo, 8'h00);
    v = q;
    repeat (4) @(posedge mclk);
    rdchk(lo, v, "stopped");
    wb(1'h1, DTM_CTRL_OFS, (md | 8'h09) << s);
    @(negedge mclk);
    `CHK(irq, 2'h1 << b, "irq on")
    wb(1'h1, DTM_CTRL_OFS, (md | 8'h01) << s);
    @(negedge mclk);
    `CHK(irq, 2'h0, "irq off")
    wb(1'h1, DTM_CTRL_OFS, 8'h00);
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    reset_n <= 1'h1;
    t_reset();
    t_timer(0, 1'h0);
    t_timer(1, 1'h1);
    summarize();
  end
  initial begin
    repeat (2000) @(posedge mclk);
    errors++;
    summarize();
  end
endmodule
